// ==== logic/fifo_flag_pkg.sv ====
// Functional notes
// - Passthrough mode holds one word more than standard; thresholds use that depth.
// - Asynchronous almost-full goes low on write edges, high on read edges.
// - Straps 000, 001, 010, 011 or 111 at reset select asynchronous partial flags.
// - Straps 100, 101 or 110 at reset select synchronous partial flags.
// - Straps 000, 001, 010, 100, 101, 110 select single device with half-full flag.
// - Passthrough with synchronous partial flags only by straps 101.
// - Straps 001 or 101 select passthrough; all others standard read timing.
// - Straps 010 or 110 select standard timing with double-registered flags.
// - Synchronous almost-empty changes only on read clock edges.
// - Synchronous almost-full changes only on write clock edges.
// - Passthrough output-ready goes low two read cycles after write, maybe one more.
// - Passthrough input-ready goes low one write cycle after read, maybe one more.
// - Synchronous almost-empty rises in current read cycle or one later.
// - Synchronous almost-full rises in current write cycle or one later.
// - Double-registered full flag rises one write cycle after read, maybe one more.
// - Double-registered empty flag rises one read cycle after write, maybe one more.
// - Asynchronous almost-empty goes low on read edges, high on write edges.
// - Straps 000, 011, 100 or 111 select standard read timing.
// - Flag register stages apply to empty and full flags only, not partial flags.
package fifo_flag_pkg;
   localparam int DATA_W = 18;
   localparam int PTR_W = 9;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] MEM_DEPTH = 10'h200;
   localparam logic [CNT_W-1:0] DEPTH_STD = 10'h200;
   localparam logic [CNT_W-1:0] DEPTH_PASS = 10'h201;
   localparam logic [CNT_W-1:0] RST_OFFSET = 10'h007;
   localparam logic [1:0] CFG_WAIT = 2'h3;
   // Strap codes, ordered first_load_strap, read_chain_in, write_chain_in
   localparam logic [2:0] STRAP_STD_A0 = 3'h0;
   localparam logic [2:0] STRAP_PASS_A = 3'h1;
   localparam logic [2:0] STRAP_DBL_A = 3'h2;
   localparam logic [2:0] STRAP_STD_A3 = 3'h3;
   localparam logic [2:0] STRAP_STD_S = 3'h4;
   localparam logic [2:0] STRAP_PASS_S = 3'h5;
   localparam logic [2:0] STRAP_DBL_S = 3'h6;
   localparam logic [2:0] STRAP_STD_A7 = 3'h7;
   // Register byte addresses
   localparam logic [3:0] OFS_EMPTY = 4'h0;
   localparam logic [3:0] OFS_FULL = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_LEVEL = 4'hC;
   // Status register bit positions
   localparam int ST_EMPTY = 0;
   localparam int ST_FULL = 1;
   localparam int ST_AE = 2;
   localparam int ST_AF = 3;
   localparam int ST_HALF = 4;
   localparam int ST_PASS = 5;
   localparam int ST_SYNC = 6;
   localparam int ST_DBL = 7;
   localparam int ST_SINGLE = 8;
   typedef struct packed {
      logic pass;
      logic sync_pf;
      logic dbl;
      logic single;
   } mode_t;
   typedef struct packed {
      logic wclk;
      logic rclk;
      logic wen_n;
      logic ren_n;
      logic [DATA_W-1:0] data;
      logic [2:0] strap;
   } pins_t;
endpackage

// ==== logic/fifo_flag_logic.sv ====
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fifo_flag_logic (
   input wire logic clock,
   input wire logic rstn,
   input wire logic write_clock_pin,
   input wire logic read_clock_pin,
   input wire logic write_enable_n,
   input wire logic read_enable_n,
   input wire logic [fifo_flag_pkg::DATA_W-1:0] data_in,
   input wire logic first_load_strap,
   input wire logic read_chain_in,
   input wire logic write_chain_in,
   output logic [fifo_flag_pkg::DATA_W-1:0] data_out,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic almost_empty_flag_n,
   output logic almost_full_flag_n,
   output logic half_full_flag_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import fifo_flag_pkg::*;

   function automatic mode_t decode(input logic [2:0] s);
      mode_t r;
      r.pass = (s == STRAP_PASS_A) || (s == STRAP_PASS_S);
      r.sync_pf = (s == STRAP_STD_S) || (s == STRAP_PASS_S) || (s == STRAP_DBL_S);
      r.dbl = (s == STRAP_DBL_A) || (s == STRAP_DBL_S);
      r.single = (s != STRAP_STD_A3) && (s != STRAP_STD_A7);
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers and clock edge detection
   // ---------------------------------------------------------------
   pins_t pin_raw;
   pins_t s1_q;
   pins_t s2_q;
   logic wclk3_q;
   logic rclk3_q;

   assign pin_raw = '{wclk: write_clock_pin, rclk: read_clock_pin, wen_n: write_enable_n,
                      ren_n: read_enable_n, data: data_in,
                      strap: {first_load_strap, read_chain_in, write_chain_in}};

   // Enables and data share the stages of their clock, so they stay aligned to its edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         wclk3_q <= 1'b0;
         rclk3_q <= 1'b0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         wclk3_q <= s2_q.wclk;
         rclk3_q <= s2_q.rclk;
      end
   end

   // ---------------------------------------------------------------
   // Configuration at reset
   // ---------------------------------------------------------------
   logic [1:0] cfg_cnt_q;
   logic [1:0] cfg_cnt_d;
   logic [2:0] strap_q;
   logic [2:0] strap_d;
   logic cfg_done;
   mode_t m;

   assign cfg_done = (cfg_cnt_q == CFG_WAIT);
   assign m = decode(strap_q);

   // Straps are sampled until the synchroniser has settled, then frozen
   always_comb begin
      cfg_cnt_d = cfg_done ? cfg_cnt_q : cfg_cnt_q + 2'h1;
      strap_d = cfg_done ? strap_q : s2_q.strap;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cfg_cnt_q <= 2'h0;
         strap_q <= STRAP_STD_A0;
      end else begin
         cfg_cnt_q <= cfg_cnt_d;
         strap_q <= strap_d;
      end
   end

   // ---------------------------------------------------------------
   // Storage and flag core
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
   logic [PTR_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, level_d, depth;
   logic [CNT_W-1:0] ae_ofs_q, af_ofs_q;
   logic [1:0] avail_q, avail_d, room_q, room_d;
   logic out_full_q, out_full_d;
   logic near_empty_q, near_empty_d, near_full_q, near_full_d, half_q, half_d;
   logic [DATA_W-1:0] dout_q, dout_d;
   logic wr_edge, rd_edge, avail_vis, room_vis;
   logic wr_acc, std_rd, pass_take, pass_load, rd_mem;
   logic ae_cond, af_cond;

   assign wr_edge = cfg_done & s2_q.wclk & ~wclk3_q;
   assign rd_edge = cfg_done & s2_q.rclk & ~rclk3_q;
   assign depth = m.pass ? DEPTH_PASS : DEPTH_STD;
   // Stage count touches only the empty and full views
   assign avail_vis = m.dbl ? avail_q[1] : avail_q[0];
   assign room_vis = (m.dbl | m.pass) ? room_q[1] : room_q[0];

   always_comb begin
      wr_acc = wr_edge & ~s2_q.wen_n & room_vis;
      std_rd = rd_edge & ~m.pass & ~s2_q.ren_n & avail_vis;
      pass_take = rd_edge & m.pass & out_full_q & ~s2_q.ren_n;
      // Output word refills without a read request, or on a read of the held one
      pass_load = rd_edge & m.pass & avail_q[1] & (cnt_q != '0) &
                  (~out_full_q | ~s2_q.ren_n);
      rd_mem = std_rd | pass_load;
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, wr_acc} - {{(CNT_W-1){1'b0}}, rd_mem};
      wptr_d = wptr_q + {{(PTR_W-1){1'b0}}, wr_acc};
      rptr_d = rptr_q + {{(PTR_W-1){1'b0}}, rd_mem};
      out_full_d = m.pass & (pass_load | (out_full_q & ~pass_take));
      level_d = cnt_d + {{(CNT_W-1){1'b0}}, out_full_d};
      dout_d = rd_mem ? mem[rptr_q] : dout_q;
      // Far-side news crosses on own-side edges; own-side emptying or filling shows at once
      avail_d = rd_edge ? {avail_q[0], cnt_d != '0} : avail_q;
      if (cnt_d == '0) begin
         avail_d = 2'h0;
      end
      room_d = wr_edge ? {room_q[0], cnt_d < MEM_DEPTH} : room_q;
      if (cnt_d >= MEM_DEPTH) begin
         room_d = 2'h0;
      end
      ae_cond = level_d <= ae_ofs_q;
      af_cond = (depth - level_d) <= af_ofs_q;
      near_empty_d = near_empty_q;
      near_full_d = near_full_q;
      if (m.sync_pf) begin
         if (rd_edge) begin
            near_empty_d = ~ae_cond;
         end
         if (wr_edge) begin
            near_full_d = ~af_cond;
         end
      end else begin
         if (rd_edge && ae_cond) begin
            near_empty_d = 1'b0;
         end else if (wr_edge && !ae_cond) begin
            near_empty_d = 1'b1;
         end
         if (wr_edge && af_cond) begin
            near_full_d = 1'b0;
         end else if (rd_edge && !af_cond) begin
            near_full_d = 1'b1;
         end
      end
      half_d = ~(m.single & (level_d > {1'b0, depth[CNT_W-1:1]}));
   end

   always_ff @(posedge clock) begin
      if (wr_acc) begin
         mem[wptr_q] <= s2_q.data;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         out_full_q <= 1'b0;
         dout_q <= '0;
         avail_q <= 2'h0;
         room_q <= 2'h3;
         near_empty_q <= 1'b0;
         near_full_q <= 1'b1;
         half_q <= 1'b1;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q <= cnt_d;
         out_full_q <= out_full_d;
         dout_q <= dout_d;
         avail_q <= avail_d;
         room_q <= room_d;
         near_empty_q <= near_empty_d;
         near_full_q <= near_full_d;
         half_q <= half_d;
      end
   end

   assign data_out = dout_q;
   assign empty_flag_n = m.pass ? ~out_full_q : avail_vis;
   assign full_flag_n = m.pass ? ~room_vis : room_vis;
   assign almost_empty_flag_n = near_empty_q;
   assign almost_full_flag_n = near_full_q;
   assign half_full_flag_n = half_q;

   // ---------------------------------------------------------------
   // Avalon-MM slave, one wait state on every access
   // ---------------------------------------------------------------
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic [CNT_W-1:0] ae_ofs_d, af_ofs_d, level;
   logic [31:0] status;

   assign level = cnt_q + {{(CNT_W-1){1'b0}}, out_full_q};
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata = rdata_q;

   always_comb begin
      status = '0;
      status[ST_EMPTY] = empty_flag_n;
      status[ST_FULL] = full_flag_n;
      status[ST_AE] = near_empty_q;
      status[ST_AF] = near_full_q;
      status[ST_HALF] = half_q;
      status[ST_PASS] = m.pass;
      status[ST_SYNC] = m.sync_pf;
      status[ST_DBL] = m.dbl;
      status[ST_SINGLE] = m.single;
      ack_d = (avs_read | avs_write) & ~ack_q;
      rdata_d = rdata_q;
      if (avs_read && !ack_q) begin
         if (avs_address == OFS_EMPTY) begin
            rdata_d = {22'h0, ae_ofs_q};
         end else if (avs_address == OFS_FULL) begin
            rdata_d = {22'h0, af_ofs_q};
         end else if (avs_address == OFS_STATUS) begin
            rdata_d = status;
         end else if (avs_address == OFS_LEVEL) begin
            rdata_d = {22'h0, level};
         end else begin
            rdata_d = '0;
         end
      end
      ae_ofs_d = ae_ofs_q;
      af_ofs_d = af_ofs_q;
      if (avs_write && ack_q) begin
         if (avs_address == OFS_EMPTY) begin
            if (avs_byteenable[0]) ae_ofs_d[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1]) ae_ofs_d[9:8] = avs_writedata[9:8];
         end else if (avs_address == OFS_FULL) begin
            if (avs_byteenable[0]) af_ofs_d[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1]) af_ofs_d[9:8] = avs_writedata[9:8];
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
         ae_ofs_q <= RST_OFFSET;
         af_ofs_q <= RST_OFFSET;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ae_ofs_q <= ae_ofs_d;
         af_ofs_q <= af_ofs_d;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_pass_load;
      rd_edge && m.pass && avail_q[1] && !out_full_q;
   endsequence
   sequence s_word_out;
      !empty_flag_n && (data_out == $past(mem[rptr_q]));
   endsequence

   property p_depth;
      @(posedge clock) disable iff (!rstn) level <= depth;
   endproperty
   a_depth: assert property (p_depth) else $error("level above depth");
   property p_async_near_full;
      @(posedge clock) disable iff (!rstn)
         !m.sync_pf && $fell(almost_full_flag_n) |-> $past(wr_edge);
   endproperty
   a_async_near_full: assert property (p_async_near_full) else $error("almost-full fell off write edge");
   property p_async_near_empty;
      @(posedge clock) disable iff (!rstn)
         !m.sync_pf && $rose(almost_empty_flag_n) |-> $past(wr_edge);
   endproperty
   a_async_near_empty: assert property (p_async_near_empty) else $error("almost-empty rose off write edge");
   property p_sync_near_empty;
      @(posedge clock) disable iff (!rstn)
         m.sync_pf && $changed(almost_empty_flag_n) |-> $past(rd_edge);
   endproperty
   a_sync_near_empty: assert property (p_sync_near_empty) else $error("almost-empty moved off read edge");
   property p_sync_near_full;
      @(posedge clock) disable iff (!rstn)
         m.sync_pf && $changed(almost_full_flag_n) |-> $past(wr_edge);
   endproperty
   a_sync_near_full: assert property (p_sync_near_full) else $error("almost-full moved off write edge");
   // Once configured, the mode must not follow later strap movement
   property p_mode;
      @(posedge clock) disable iff (!rstn)
         cfg_done |=> cfg_done && $stable(strap_q);
   endproperty
   a_mode: assert property (p_mode) else $error("mode moved after configuration");
   property p_full_ignore;
      @(posedge clock) disable iff (!rstn)
         wr_edge && !room_vis && !rd_mem |=> cnt_q == $past(cnt_q) && wptr_q == $past(wptr_q);
   endproperty
   a_full_ignore: assert property (p_full_ignore) else $error("write taken while full");
   property p_half;
      @(posedge clock) disable iff (!rstn)
         m.single && (level > {1'b0, depth[CNT_W-1:1]}) |-> !half_full_flag_n;
   endproperty
   a_half: assert property (p_half) else $error("half-full not low");
   property p_pass_load;
      @(posedge clock) disable iff (!rstn) s_pass_load |=> s_word_out;
   endproperty
   a_pass_load: assert property (p_pass_load) else $error("passthrough word not shown");
endmodule

// ==== testbench/fifo_pins_partner.sv ====
`timescale 1ns/1ps
module fifo_pins_partner (
   input wire logic clock,
   input wire logic run,
   input wire logic wr_req,
   input wire logic rd_req,
   input wire logic [fifo_flag_pkg::DATA_W-1:0] wdata,
   output logic write_clock_pin,
   output logic read_clock_pin,
   output logic write_enable_n,
   output logic read_enable_n,
   output logic [fifo_flag_pkg::DATA_W-1:0] data_in,
   output logic wr_took,
   output logic rd_took
);
   import fifo_flag_pkg::*;
   int wc;
   int rc;
   // ----------------------------------------
   // Free-running pin clocks, unrelated periods
   // ----------------------------------------
   // Enables and data move on the falling pin edge so they are stable at the rise
   always @(posedge clock) begin
      wr_took <= 1'b0;
      rd_took <= 1'b0;
      if (!run) begin
         wc <= 0;
         rc <= 0;
         write_clock_pin <= 1'b0;
         read_clock_pin <= 1'b0;
         write_enable_n <= 1'b1;
         read_enable_n <= 1'b1;
         data_in <= ~data_in;
      end else begin
         wc <= (wc == 7) ? 0 : wc + 1;
         rc <= (rc == 9) ? 0 : rc + 1;
         if (wc == 0) begin
            write_clock_pin <= 1'b1;
            wr_took <= !write_enable_n;
         end
         if (wc == 4) begin
            write_clock_pin <= 1'b0;
            write_enable_n <= !wr_req;
            // Idle data is not left at the last value
            data_in <= wr_req ? wdata : ~data_in;
         end
         if (rc == 0) begin
            read_clock_pin <= 1'b1;
            rd_took <= !read_enable_n;
         end
         if (rc == 5) begin
            read_clock_pin <= 1'b0;
            read_enable_n <= !rd_req;
         end
      end
   end
   initial begin
      data_in = '0;
   end
endmodule

// ==== testbench/dual_clock_fifo_flag_logic_tb.sv ====
`timescale 1ns/1ps
module dual_clock_fifo_flag_logic_tb;
   import fifo_flag_pkg::*;
   logic clock = 1'b0, rstn = 1'b0, run = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
   logic [2:0] strap = 3'h0;
   logic [DATA_W-1:0] wdata = '0, data_out, data_in, exp_rd;
   logic wclk, rclk, wen_n, ren_n, wr_took, rd_took;
   logic empty_n, full_n, ae_n, af_n, half_n, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [DATA_W-1:0] q[$];
   int n_fail = 0, tests_run = 0, cycles = 0, depth = 512, seed = 32'h18fa;
   initial begin
      forever #5 clock = ~clock;
   end
   fifo_pins_partner fifo_pins_partner_inst (.clock(clock), .run(run), .wr_req(wr_req),
      .rd_req(rd_req), .wdata(wdata), .write_clock_pin(wclk), .read_clock_pin(rclk),
      .write_enable_n(wen_n), .read_enable_n(ren_n), .data_in(data_in), .wr_took(wr_took),
      .rd_took(rd_took));
   fifo_flag_logic fifo_flag_logic_inst (.clock(clock), .rstn(rstn), .write_clock_pin(wclk),
      .read_clock_pin(rclk), .write_enable_n(wen_n), .read_enable_n(ren_n), .data_in(data_in),
      .first_load_strap(strap[2]), .read_chain_in(strap[1]), .write_chain_in(strap[0]),
      .data_out(data_out), .empty_flag_n(empty_n), .full_flag_n(full_n),
      .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n), .half_full_flag_n(half_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // ----------------------------------------
   // Reference model: queue of stored words
   // ----------------------------------------
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_fail = n_fail + 1;
         results();
      end
      if (wr_took) begin
         wdata <= DATA_W'($random(seed));
         if (q.size() < depth) q.push_back(data_in);
      end
      if (rd_took && q.size() > 0) exp_rd <= q.pop_front();
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // Bus master and pin helpers
   // ----------------------------------------
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      // Only the bench timeout ends a wait that never gets its answer
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic do_reset(input logic [2:0] s);
      run <= 1'b0;
      rstn <= 1'b0;
      strap <= s;
      q.delete();
      depth = (s == STRAP_PASS_A || s == STRAP_PASS_S) ? DEPTH_PASS : DEPTH_STD;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      // Mode is valid only once the straps have been synchronised and frozen
      repeat (5) @(posedge clock);
   endtask
   task automatic write_n(input int k);
      int got;
      got = 0;
      wr_req <= 1'b1;
      while (got < k) begin
         @(posedge clock);
         if (wr_took === 1'b1) got++;
      end
      wr_req <= 1'b0;
      repeat (80) @(posedge clock);
   endtask
   task automatic read_one();
      int n;
      n = 0;
      rd_req <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (rd_took !== 1'b1 && n < 40);
      rd_req <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
   // ----------------------------------------
   // One full traffic pass for a given mode
   // ----------------------------------------
   task automatic run_mode(input logic [2:0] s);
      logic pass;
      pass = (s == STRAP_PASS_A || s == STRAP_PASS_S);
      do_reset(s);
      bus(1'b0, OFS_EMPTY, 32'h0);
      check(rd, 32'h7);
      bus(1'b0, OFS_FULL, 32'h0);
      check(rd, 32'h7);
      bus(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, OFS_EMPTY, 32'h3);
      bus(1'b0, OFS_EMPTY, 32'h0);
      check(rd, 32'h3);
      bus(1'b1, OFS_LEVEL, 32'h155);
      bus(1'b0, OFS_LEVEL, 32'h0);
      check(rd, 32'h0);
      run <= 1'b1;
      write_n(3);
      check(32'(ae_n), 32'h0);
      if (pass) check(32'({empty_n, data_out}), 32'({1'b0, q[0]}));
      write_n(1);
      check(32'(ae_n), 32'h1);
      // Keep writing past full: the extra attempts must be dropped
      write_n(depth - 4 + 5);
      bus(1'b0, OFS_LEVEL, 32'h0);
      check(rd, 32'(depth));
      check(32'({full_n, af_n, half_n}), pass ? 32'h4 : 32'h0);
      // Drain everything, then one read into an empty memory
      repeat (depth) begin
         // Passthrough shows the head word before it is read
         if (pass) check(32'({empty_n, data_out}), 32'({1'b0, q[0]}));
         read_one();
         if (!pass) check(32'(data_out), 32'(exp_rd));
      end
      read_one();
      repeat (80) @(posedge clock);
      bus(1'b0, OFS_LEVEL, 32'h0);
      check(rd, 32'h0);
      check(32'({empty_n, full_n, ae_n, af_n, half_n}), pass ? 32'h13 : 32'h0B);
   endtask
   initial begin
      for (int s = 0; s < 8; s++) begin
         do_reset(3'(s));
         bus(1'b0, OFS_STATUS, 32'h0);
         // Mode bits then hf, af, ae after reset
         check(32'(rd[8:2]), 32'({s != 3 && s != 7, s == 2 || s == 6, s >= 4 && s != 7,
            s == 1 || s == 5, 3'b110}));
         bus(1'b1, OFS_STATUS, 32'h0);
         bus(1'b0, OFS_STATUS, 32'h0);
         check(32'(rd[8:5]), 32'({s != 3 && s != 7, s == 2 || s == 6, s >= 4 && s != 7,
            s == 1 || s == 5}));
      end
      run_mode(STRAP_STD_A0);
      run_mode(STRAP_DBL_S);
      run_mode(STRAP_PASS_A);
      run_mode(STRAP_PASS_S);
      results();
   end
endmodule
